// ==== hdl/asa_params.svh ====
// Register offsets, field positions, reset values and timing counts.
`ifndef ASA_PARAMS_SVH
`define ASA_PARAMS_SVH
`define A_CTRL 8'h00
`define A_CHEN 8'h04
`define A_CHDIR 8'h08
`define A_DRIVE 8'h0C
`define A_ALSEL 8'h10
`define A_ZCCFG 8'h14
`define A_STATUS 8'h18
`define A_MASK 8'h1C
`define A_RESULT 8'h20
`define A_STATS 8'h24
`define A_RMS 8'h28
`define A_GPI 8'h2C
`define A_THR_PAGE 3'h2
`define F_MODE 1:0
`define F_STATS 2
`define F_RMS 3
`define F_RMSSUB 4
`define F_OSR 7:5
`define F_RMSN 11:8
`define F_RMSCH 14:12
`define F_ZCEN 15
`define F_ZCCH 18:16
`define F_BLKEN 19
`define F_HYST 23:20
`define F_MANCH 26:24
`define CTRL_MASK 32'h07FFFFFF
`define R_CHEN 8'h01
`define R_ALSEL 24'h0000FF
`define R_ZCCFG 16'h0032
`define RMS_LOG_MAX 4'hA
`define ZC_LEVEL 12'h800
`define CLK_MHZ 25
`define OSC_NS 10000
`define OSC_CYC (`OSC_NS * `CLK_MHZ / 1000)
`endif

// ==== hdl/asa_pkg.sv ====
// Types shared by the converter control logic.
package asa_pkg;
    typedef enum logic [1:0] {MODE_MANUAL, MODE_AUTOSEQ, MODE_AUTON} asa_mode_e;
    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_SEND} asa_state_e;
    typedef struct packed {
        asa_state_e st;
        logic [31:0] ctrl;
        logic [7:0] chEn;
        logic [15:0] chDir;
        logic [15:0] drive;
        logic [23:0] alSel;
        logic [15:0] zcCfg;
        logic [23:0] status;
        logic [23:0] mask;
        logic [7:0][27:0] thr;
        logic [2:0] ch;
        logic [7:0] osrCnt;
        logic [19:0] acc;
        logic [11:0] result;
        logic [2:0] resCh;
        logic resValid;
        logic [11:0] minV;
        logic [11:0] maxV;
        logic [33:0] sumSq;
        logic [21:0] sum;
        logic [10:0] rmsCnt;
        logic [11:0] rms;
        logic [7:0] rgnHi;
        logic [7:0] rgnLo;
        logic [2:0] sclSy;
        logic [2:0] sdaSy;
        logic [7:0] gpiS1;
        logic [7:0] gpiS2;
        logic [7:0] gpiPrev;
        logic [15:0] shift;
        logic [4:0] bitCnt;
        logic autoRun;
        logic [15:0] oscCnt;
        logic zcState;
        logic [7:0] blankCnt;
        logic adcStart;
        logic [2:0] adcCh;
        logic [7:0] gpoOut;
        logic [7:0] gpoOen;
        logic sdaOut;
        logic sdaOen;
        logic alert;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } asa_state_s;
endpackage

// ==== hdl/adc_sequencer_alert_control.sv ====
// Eight-channel converter control: sequencing, alerts, zero-cross, averaging and RMS.
//
// Summary of operation
// RULE1 - Each channel enables separately and is analog input, digital input or output.
// RULE2 - Selected analog channels flag and alert on high or low threshold, with hysteresis.
// RULE3 - Selected digital inputs flag and alert on the chosen edge kind.
// RULE4 - Digital outputs are open-drain unless push-pull is selected.
// RULE5 - Zero-cross detector can be enabled and its state steers mapped outputs.
// RULE6 - Zero-cross detector watches exactly one selected channel.
// RULE7 - Zero-cross changes are suppressed during an optional blanking interval.
// RULE8 - Host start condition begins a manual conversion; result shifts out on the bus.
// RULE9 - Auto-sequence steps through enabled analog channels in ascending order.
// RULE10 - Host keeps clocking the bus during auto-sequence.
// RULE11 - Autonomous mode restarts conversions from the internal oscillator.
// RULE12 - Autonomous mode returns no data; only the alert output reports. The code also drives irq for flags enabled in the mask.
// RULE13 - Reset leaves manual mode; only a control write changes the mode.
// RULE14 - One oversampling ratio applies to every analog channel.
// RULE15 - Statistics (minimum and maximum) switch on or off independently.
// RULE16 - RMS over N samples, root of mean square minus optional mean.
// RULE17 - Event flags stay set until software clears them.
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "asa_params.svh"

module adc_sequencer_alert_control #(
    parameter int AUTO_PERIOD = `OSC_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOen,
    output logic adcStart,
    output logic [2:0] adcCh,
    input wire logic adcDone,
    input wire logic [11:0] adcData,
    input wire logic [7:0] gpioIn,
    output logic [7:0] gpoOut,
    output logic [7:0] gpoOen,
    output logic alert,
    output logic irq
);

    asa_pkg::asa_state_s s;
    asa_pkg::asa_state_s n;
    asa_pkg::asa_mode_e mode;
    logic [7:0] anMask;
    logic [7:0] dinMask;
    logic [7:0] doutMask;
    logic anyAn;
    logic sclFall;
    logic busStart;
    logic setup;
    logic wr;
    logic [2:0] osr;
    logic osrLast;
    logic [19:0] accN;
    logic [11:0] avgRes;
    logic [3:0] rmsLog;
    logic [33:0] sumSqN;
    logic [21:0] sumN;
    logic [11:0] mean;
    logic [11:0] hi;
    logic [11:0] lo;
    logic [12:0] hyst;
    logic zcNew;
    logic issue;
    logic [2:0] issCh;
    logic [23:0] setV;
    logic [23:0] clrV;
    logic [7:0] gpoVal;

    ////////////////////////////////////////////////////////////////////////////////

    // Next set bit of m after cur, wrapping; cur itself when no other is set.
    function automatic logic [2:0] nextCh(input logic [7:0] m, input logic [2:0] cur);
        logic [2:0] k;
        logic [2:0] r;
        r = cur;
        for (int i = 7; i >= 1; i--) begin
            k = cur + 3'(i);
            if (m[k]) begin
                r = k;
            end
        end
        return r;
    endfunction

    function automatic logic [11:0] isqrt(input logic [23:0] v);
        logic [11:0] r;
        logic [11:0] c;
        r = 12'h000;
        for (int i = 11; i >= 0; i--) begin
            c = r | (12'h001 << i);
            if (24'(c) * 24'(c) <= v) begin
                r = c;
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////

    assign mode = asa_pkg::asa_mode_e'(s.ctrl[`F_MODE]);
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            anMask[i] = s.chEn[i] & (s.chDir[2*i +: 2] == 2'h0); // RULE1
            dinMask[i] = s.chEn[i] & (s.chDir[2*i +: 2] == 2'h1);
            doutMask[i] = s.chEn[i] & (s.chDir[2*i +: 2] == 2'h2);
        end
    end
    assign anyAn = |anMask;
    assign sclFall = s.sclSy[2] & ~s.sclSy[1];
    // Start is ignored while the block drives data, since its own SDA edges would alias.
    assign busStart = s.sclSy[1] & s.sdaSy[2] & ~s.sdaSy[1] & (s.st != asa_pkg::ST_SEND);
    assign setup = psel & ~penable & ~s.pready;
    assign wr = psel & penable & pwrite & s.pready;
    assign osr = s.ctrl[`F_OSR];
    assign osrLast = s.osrCnt == 8'((8'h01 << osr) - 8'h01); // RULE14
    assign accN = s.acc + 20'(adcData);
    assign avgRes = 12'(accN >> osr);
    assign rmsLog = (s.ctrl[`F_RMSN] > `RMS_LOG_MAX) ? `RMS_LOG_MAX : s.ctrl[`F_RMSN];
    assign sumSqN = s.sumSq + 34'(24'(avgRes) * 24'(avgRes));
    assign sumN = s.sum + 22'(avgRes);
    assign mean = 12'(sumN >> rmsLog);
    assign hi = s.thr[s.ch][11:0];
    assign lo = s.thr[s.ch][27:16];
    assign hyst = 13'(s.ctrl[`F_HYST]);
    assign zcNew = avgRes >= `ZC_LEVEL;

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        n = s;
        issue = 1'b0;
        issCh = s.ch;
        setV = 24'h000000;
        clrV = 24'h000000;
        gpoVal = 8'h00;
        n.adcStart = 1'b0;
        n.sclSy = {s.sclSy[1:0], sclIn};
        n.sdaSy = {s.sdaSy[1:0], sdaIn};
        n.gpiS1 = gpioIn;
        n.gpiS2 = s.gpiS1;
        n.gpiPrev = s.gpiS2;
        n.pready = setup;
        n.pslverr = 1'b0;
        if (setup) begin
            n.prdata = 32'h00000000;
            if (paddr == `A_CTRL) begin
                n.prdata = s.ctrl;
            end else if (paddr == `A_CHEN) begin
                n.prdata = {24'h000000, s.chEn};
            end else if (paddr == `A_CHDIR) begin
                n.prdata = {16'h0000, s.chDir};
            end else if (paddr == `A_DRIVE) begin
                n.prdata = {16'h0000, s.drive};
            end else if (paddr == `A_ALSEL) begin
                n.prdata = {8'h00, s.alSel};
            end else if (paddr == `A_ZCCFG) begin
                n.prdata = {16'h0000, s.zcCfg};
            end else if (paddr == `A_STATUS) begin
                n.prdata = {8'h00, s.status};
            end else if (paddr == `A_MASK) begin
                n.prdata = {8'h00, s.mask};
            end else if (paddr == `A_RESULT) begin
                n.prdata = {15'h0000, s.resValid, 1'b0, s.resCh, s.result};
            end else if (paddr == `A_STATS) begin
                n.prdata = {4'h0, s.maxV, 4'h0, s.minV};
            end else if (paddr == `A_RMS) begin
                n.prdata = {20'h00000, s.rms};
            end else if (paddr == `A_GPI) begin
                n.prdata = {23'h000000, s.zcState, s.gpiS2};
            end else if (paddr[7:5] == `A_THR_PAGE && paddr[1:0] == 2'h0) begin
                n.prdata = {4'h0, s.thr[paddr[4:2]]};
            end else begin
                n.pslverr = 1'b1;
            end
        end
        if (wr) begin
            if (paddr == `A_CTRL) begin
                n.ctrl = pwdata & `CTRL_MASK; // RULE13
            end else if (paddr == `A_CHEN) begin
                n.chEn = pwdata[7:0]; // RULE1
            end else if (paddr == `A_CHDIR) begin
                n.chDir = pwdata[15:0];
            end else if (paddr == `A_DRIVE) begin
                n.drive = pwdata[15:0];
            end else if (paddr == `A_ALSEL) begin
                n.alSel = pwdata[23:0];
            end else if (paddr == `A_ZCCFG) begin
                n.zcCfg = pwdata[15:0];
            end else if (paddr == `A_STATUS) begin
                clrV = pwdata[23:0];
            end else if (paddr == `A_MASK) begin
                n.mask = pwdata[23:0];
            end else if (paddr[7:5] == `A_THR_PAGE && paddr[1:0] == 2'h0) begin
                n.thr[paddr[4:2]] = {pwdata[27:16], 4'h0, pwdata[11:0]};
            end
        end

        for (int i = 0; i < 8; i++) begin
            if (s.alSel[i] && dinMask[i]) begin
                setV[16+i] = (s.alSel[8+i] & s.gpiS2[i] & ~s.gpiPrev[i])
                           | (s.alSel[16+i] & ~s.gpiS2[i] & s.gpiPrev[i]); // RULE3
            end
        end

        if (mode != asa_pkg::MODE_AUTON) begin
            n.autoRun = 1'b0;
        end else if (s.autoRun) begin
            n.oscCnt = (s.oscCnt == 16'h0000) ? 16'(AUTO_PERIOD - 1) : s.oscCnt - 16'h0001;
        end

        case (s.st)
            asa_pkg::ST_IDLE: begin
                if (busStart && mode == asa_pkg::MODE_MANUAL) begin
                    issue = 1'b1; // RULE8
                    issCh = s.ctrl[`F_MANCH];
                end else if (busStart && mode != asa_pkg::MODE_MANUAL && anyAn) begin
                    issue = mode != asa_pkg::MODE_AUTON || !s.autoRun;
                    issCh = nextCh(anMask, 3'h7); // RULE9
                    if (mode == asa_pkg::MODE_AUTON) begin
                        n.autoRun = 1'b1;
                        n.oscCnt = 16'(AUTO_PERIOD - 1);
                    end
                end else if (s.autoRun && mode == asa_pkg::MODE_AUTON && s.oscCnt == 16'h0000
                             && anyAn) begin
                    issue = 1'b1; // RULE11
                    issCh = nextCh(anMask, s.ch);
                end
            end
            asa_pkg::ST_SAMPLE: begin
                if (adcDone && !osrLast) begin
                    n.acc = accN;
                    n.osrCnt = s.osrCnt + 8'h01;
                    n.adcStart = 1'b1; // RULE14
                end else if (adcDone) begin
                    n.result = avgRes;
                    n.resCh = s.ch;
                    n.resValid = 1'b1;
                    if (s.alSel[s.ch] && anMask[s.ch]) begin
                        if (avgRes > hi && !s.rgnHi[s.ch]) begin
                            setV[s.ch] = 1'b1; // RULE2
                            n.rgnHi[s.ch] = 1'b1;
                        end else if (s.rgnHi[s.ch] && 13'(avgRes) + hyst < 13'(hi)) begin
                            n.rgnHi[s.ch] = 1'b0;
                        end
                        if (avgRes < lo && !s.rgnLo[s.ch]) begin
                            setV[8 + s.ch] = 1'b1; // RULE2
                            n.rgnLo[s.ch] = 1'b1;
                        end else if (s.rgnLo[s.ch] && 13'(avgRes) > 13'(lo) + hyst) begin
                            n.rgnLo[s.ch] = 1'b0;
                        end
                    end
                    if (s.ctrl[`F_STATS]) begin
                        n.minV = (avgRes < s.minV) ? avgRes : s.minV; // RULE15
                        n.maxV = (avgRes > s.maxV) ? avgRes : s.maxV;
                    end
                    if (s.ctrl[`F_RMS] && s.ch == s.ctrl[`F_RMSCH]) begin
                        n.sumSq = sumSqN;
                        n.sum = sumN;
                        n.rmsCnt = s.rmsCnt + 11'h001;
                        if (s.rmsCnt == 11'((11'h001 << rmsLog) - 11'h001)) begin
                            n.rms = isqrt(24'(sumSqN >> rmsLog))
                                  - (s.ctrl[`F_RMSSUB] ? mean : 12'h000); // RULE16
                            n.sumSq = 34'h0;
                            n.sum = 22'h0;
                            n.rmsCnt = 11'h000;
                        end
                    end
                    if (s.ctrl[`F_ZCEN] && s.ch == s.ctrl[`F_ZCCH]) begin // RULE6
                        if (s.ctrl[`F_BLKEN] && s.blankCnt != 8'h00) begin
                            n.blankCnt = s.blankCnt - 8'h01; // RULE7
                        end else if (zcNew != s.zcState) begin
                            n.zcState = zcNew; // RULE5
                            n.blankCnt = s.zcCfg[7:0];
                        end
                    end
                    if (mode == asa_pkg::MODE_AUTON) begin
                        n.st = asa_pkg::ST_IDLE; // RULE12
                    end else begin
                        n.shift = {1'b0, s.ch, avgRes};
                        n.bitCnt = 5'h10;
                        n.st = asa_pkg::ST_SEND; // RULE8
                    end
                end
            end
            asa_pkg::ST_SEND: begin
                if (sclFall && s.bitCnt != 5'h00) begin
                    n.sdaOen = s.shift[15];
                    n.shift = {s.shift[14:0], 1'b0};
                    n.bitCnt = s.bitCnt - 5'h01;
                end else if (sclFall) begin
                    n.sdaOen = 1'b1;
                    n.st = asa_pkg::ST_IDLE;
                    if (mode == asa_pkg::MODE_AUTOSEQ && anyAn) begin
                        issue = 1'b1; // RULE9
                        issCh = nextCh(anMask, s.ch);
                    end
                end
            end
            default: begin
                n.st = asa_pkg::ST_IDLE;
            end
        endcase

        if (issue) begin
            n.ch = issCh;
            n.adcCh = issCh;
            n.adcStart = 1'b1;
            n.osrCnt = 8'h00;
            n.acc = 20'h00000;
            n.st = asa_pkg::ST_SAMPLE;
        end
        if (!n.ctrl[`F_STATS]) begin
            n.minV = 12'hFFF;
            n.maxV = 12'h000;
        end
        if (!n.ctrl[`F_RMS]) begin
            n.sumSq = 34'h0;
            n.sum = 22'h0;
            n.rmsCnt = 11'h000;
        end

        // A hardware event in the clearing cycle survives the clear.
        n.status = (s.status & ~clrV) | setV; // RULE17
        n.alert = |n.status;
        n.irq = |(n.status & n.mask);
        for (int i = 0; i < 8; i++) begin
            gpoVal[i] = s.zcCfg[8+i] ? n.zcState : n.drive[8+i]; // RULE5
            n.gpoOut[i] = n.drive[i] & gpoVal[i]; // RULE4
            n.gpoOen[i] = ~(doutMask[i] & (n.drive[i] | ~gpoVal[i]));
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
            s.chEn <= `R_CHEN;
            s.alSel <= `R_ALSEL;
            s.zcCfg <= `R_ZCCFG;
            s.minV <= 12'hFFF;
            s.sdaOen <= 1'b1;
            s.gpoOen <= 8'hFF;
        end else begin
            s <= n;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign sdaOut = s.sdaOut;
    assign sdaOen = s.sdaOen;
    assign adcStart = s.adcStart;
    assign adcCh = s.adcCh;
    assign gpoOut = s.gpoOut;
    assign gpoOen = s.gpoOen;
    assign alert = s.alert;
    assign irq = s.irq;

    ////////////////////////////////////////////////////////////////////////////////

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_nodrive;
        1 |=> ((~$past(doutMask)) & ~gpoOen) == 8'h00;
    endproperty
    a_nodrive: assert property (p_nodrive) else $error("undriven channel drives"); // RULE1

    property p_highFlag;
        |setV[7:0] |=> ((s.status[7:0] & $past(setV[7:0])) == $past(setV[7:0])) ##1 alert;
    endproperty
    a_highFlag: assert property (p_highFlag) else $error("threshold flag lost"); // RULE2

    property p_digFlag;
        |setV[23:16] |=> (s.status[23:16] & $past(setV[23:16])) == $past(setV[23:16]);
    endproperty
    a_digFlag: assert property (p_digFlag) else $error("edge flag lost"); // RULE3

    property p_openDrain;
        1 |=> ((~$past(n.drive[7:0])) & gpoOut) == 8'h00;
    endproperty
    a_openDrain: assert property (p_openDrain) else $error("open-drain drove high"); // RULE4

    property p_blank;
        (s.blankCnt != 8'h00 && s.ctrl[`F_BLKEN]) |=> $stable(s.zcState);
    endproperty
    a_blank: assert property (p_blank) else $error("zero-cross change in blanking"); // RULE7

    property p_seqCh;
        (adcStart && mode != asa_pkg::MODE_MANUAL && s.osrCnt == 8'h00) |-> anMask[adcCh];
    endproperty
    a_seqCh: assert property (p_seqCh) else $error("sequence picked non-analog"); // RULE9

    property p_osc;
        (s.autoRun && mode == asa_pkg::MODE_AUTON && s.st == asa_pkg::ST_IDLE
         && s.oscCnt == 16'h0000 && anyAn) |=> adcStart;
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator start missing"); // RULE11

    property p_quiet;
        (mode == asa_pkg::MODE_AUTON) [*2] |-> sdaOen;
    endproperty
    a_quiet: assert property (p_quiet) else $error("data driven in autonomous"); // RULE12

    property p_modeHold;
        !(wr && paddr == `A_CTRL) |=> $stable(mode);
    endproperty
    a_modeHold: assert property (p_modeHold) else $error("mode changed unbidden"); // RULE13

    property p_sticky;
        !(wr && paddr == `A_STATUS) |=> (s.status & $past(s.status)) == $past(s.status);
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped uncleared"); // RULE17

    property p_osr;
        (s.st == asa_pkg::ST_SAMPLE && adcDone && !osrLast) |=> adcStart;
    endproperty
    a_osr: assert property (p_osr) else $error("oversample restart missing"); // RULE14

    c_send: cover property (s.st == asa_pkg::ST_SEND ##[1:1000] s.st == asa_pkg::ST_IDLE);
    c_alert: cover property ($rose(alert));
    c_auto: cover property (s.autoRun && adcStart);
    c_rms: cover property ($changed(s.rms));

endmodule

// ==== verif/asa_host_model.sv ====
// Behavioural bus host that frames conversions and clocks results out.
`timescale 1ns/100ps
module asa_host_model (
    output logic scl,
    output logic sdaDrv,
    input wire logic sdaLine
);
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end

    // SCL stands high between frames; each frame gives 17 falls after its optional start, sampling on rises.
    task automatic frame(input logic withStart, output logic [15:0] w);
        w = 16'h0000;
        if (withStart) begin
            #77 sdaDrv = 1'b0;
            #160 scl = 1'b0;
            #20 sdaDrv = 1'b1;
        end
        #2000;
        for (int i = 0; i < 17; i++) begin
            scl = 1'b1;
            if (i > 0) w = {w[14:0], sdaLine};
            #160 scl = 1'b0;
            #160;
        end
        scl = 1'b1;
        #160;
    endtask
endmodule

// ==== verif/adc_sequencer_alert_control_tb.sv ====
// Self-checking bench for the converter control block.
`timescale 1ns/100ps
`include "asa_params.svh"
module adc_sequencer_alert_control_tb;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic adcDone = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [11:0] adcData = 12'h000;
    logic [7:0] gpioIn = 8'h00;
    logic [31:0] prdata;
    logic pready, pslverr, sdaOut, sdaOen, adcStart, alert, irq, scl, sdaDrv, errBit;
    logic [2:0] adcCh;
    logic [7:0] gpoOut, gpoOen;
    logic [31:0] rd;
    logic [15:0] w;
    int n_errors = 0;
    int samples_checked = 0;
    int nStarts = 0;
    int dly = 0;
    int cyc = 0;
    int n0;
    wire sdaLine = sdaDrv & (sdaOen | sdaOut);

    always #20 clk = ~clk;

    adc_sequencer_alert_control #(.AUTO_PERIOD(8)) uut (.clk(clk), .resetn(resetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclIn(scl), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOen(sdaOen), .adcStart(adcStart), .adcCh(adcCh),
        .adcDone(adcDone), .adcData(adcData), .gpioIn(gpioIn), .gpoOut(gpoOut),
        .gpoOen(gpoOen), .alert(alert), .irq(irq));
    asa_host_model host (.scl(scl), .sdaDrv(sdaDrv), .sdaLine(sdaLine));

    // Converter answers three cycles after each start with a code built from the channel.
    always @(posedge clk) begin
        adcDone <= 1'b0;
        cyc <= cyc + 1;
        if (adcStart === 1'b1) begin
            nStarts <= nStarts + 1;
            dly <= 3;
        end else if (dly != 0) begin
            dly <= dly - 1;
            if (dly == 1) begin
                adcDone <= 1'b1;
                adcData <= {adcCh, 9'h0AB};
            end
        end
        if (cyc == 20000) begin
            n_errors++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Registered answers settle by mid-cycle; the values seen stand at the next rising edge.
        @(negedge clk);
        while (pready !== 1'b1) @(negedge clk);
        rd = prdata;
        errBit = pslverr;
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
    endtask

    task automatic rst();
        @(posedge clk);
        resetn <= 1'b0;
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rdchk(`A_CTRL, 32'h00000000);
        rdchk(`A_CHEN, 32'h00000001);
        rdchk(`A_ALSEL, 32'h000000FF);
        rdchk(`A_ZCCFG, 32'h00000032);
        rdchk(`A_STATS, 32'h00000FFF);
        rdchk(8'h30, 32'h00000000);
        chk(errBit, 1'b1);
        chk(gpoOen, 8'hFF);
    endtask

    task automatic t_manual();
        wr(`A_CHEN, 32'h00000009);
        wr(`A_STATUS, 32'h00FFFFFF);
        wr(8'h4C, 32'h01000600);
        wr(`A_CTRL, 32'h0300304C);
        n0 = nStarts;
        host.frame(1'b1, w);
        chk(w, 16'h36AB);
        chk(nStarts - n0, 32'h00000004);
        rdchk(`A_RESULT, 32'h000136AB);
        rdchk(`A_STATUS, 32'h00000008);
        rdchk(`A_STATS, 32'h06AB06AB);
        rdchk(`A_RMS, 32'h000006AB);
        chk({alert, irq}, 2'b10);
        wr(`A_MASK, 32'h00000008);
        settle();
        chk({alert, irq}, 2'b11);
        wr(`A_STATUS, 32'h00000008);
        settle();
        chk({alert, irq}, 2'b00);
    endtask

    task automatic t_gpio();
        rst();
        wr(`A_CHEN, 32'h00000061);
        wr(`A_CHDIR, 32'h00001800);
        wr(`A_DRIVE, 32'h00000000);
        settle();
        chk({gpoOen[5], gpoOut[5], gpoOen[4]}, 3'b001);
        wr(`A_DRIVE, 32'h00002000);
        settle();
        chk(gpoOen[5], 1'b1);
        wr(`A_DRIVE, 32'h00002020);
        settle();
        chk({gpoOen[5], gpoOut[5]}, 2'b01);
        wr(`A_ALSEL, 32'h00004040);
        gpioIn <= 8'h40;
        repeat (8) @(posedge clk);
        rdchk(`A_STATUS, 32'h00400000);
        chk(alert, 1'b1);
        wr(`A_STATUS, 32'h00400000);
        gpioIn <= 8'h00;
        repeat (8) @(posedge clk);
        rdchk(`A_STATUS, 32'h00000000);
        chk(alert, 1'b0);
    endtask

    task automatic t_auton();
        rst();
        wr(8'h40, 32'h00000050);
        wr(`A_CTRL, 32'h00000002);
        host.frame(1'b1, w);
        chk(w, 16'hFFFF);
        n0 = nStarts;
        repeat (80) @(posedge clk);
        chk((nStarts - n0) >= 6, 1'b1);
        chk(alert, 1'b1);
    endtask

    task automatic t_autoseq();
        rst();
        wr(`A_CHEN, 32'h00000005);
        wr(`A_CTRL, 32'h00000001);
        host.frame(1'b1, w);
        chk(w, 16'h00AB);
        host.frame(1'b0, w);
        chk(w, 16'h24AB);
    endtask

    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_manual();
        t_gpio();
        t_auton();
        t_autoseq();
        stop_test();
    end
endmodule
